// File: common/bmpm_defines.svh
// Constants of the boot mode and program map block.
// Assumes inclusion by its bare name from the package and the design modules.
// Notes on behaviour
// - Oscillator high gain bit resets to 0; software sets 1 for crystal or clock.
// - At release the secured bit copies flash security; layout bit copies boot pin.
// - Secured flash with boot pin high is forced to internal boot state 00.
// - Secured internal boot: 16 address lines, no external program space, debug off.
// - Unsecured with boot pin high boots externally; line count follows wide strap.
// - Secured bit changes only at reset, never later.
// - Software cannot alter the secured bit, map or flash security through it.
// - Layout 0 internal map, 1 external map; writes ignored when secured at reset.
// - Out of reset chip select zero is program strobe, one is data strobe.
// - In external boot, wide strap high gives address bits 19:16, 20 lines; else 16 lines.
// - Internal boot vectors at 04 0000 and 04 0002; flash at lowest addresses.
// - External narrow boot: 00 0000 to 00 FFFF external, vectors 0 and 2.
// - External wide boot: boot flash window at 04 0000 goes external.
// - No external access above 00 FFFF or 0F FFFF before pin setup.
// - Shadowing internal program space needs 18 address lines.
// - Two flash blocks; fetching from a busy block is flagged.
// - Flash writes only via flash unit and single words on core write bus.
// - Data flash read serves core read bus or secondary bus, never both.
// - Modes latch at reset release; internal reset ends after a fixed count.
`ifndef BMPM_DEFINES_SVH
`define BMPM_DEFINES_SVH
// ==========================================================================
// Widths and reset timing
`define BMPM_PADDR_W      21
`define BMPM_CNT_W        6
`define BMPM_RESET_HOLD   32
// ==========================================================================
// Program address map
`define BMPM_EXT_LOW_END  21'h00ffff
`define BMPM_FLASH1_BASE  21'h020000
`define BMPM_FLASH_END    21'h03ffff
`define BMPM_BOOT_BASE    21'h040000
`define BMPM_BOOT_END     21'h043fff
`define BMPM_RAM_BASE     21'h04f800
`define BMPM_RAM_END      21'h04ffff
`define BMPM_WIDE_END     21'h0fffff
`define BMPM_EXT_BOOT_VEC 21'h000000
`define BMPM_COP_OFFSET   21'h000002
// ==========================================================================
// Address line configuration and reset values
`define BMPM_LINES_NARROW 5'h10
`define BMPM_LINES_SHADOW 5'h12
`define BMPM_LINES_WIDE   5'h14
`define BMPM_HI_ADDR_ON   4'hf
`define BMPM_HI_ADDR_OFF  4'h0
`define BMPM_OSC_GAIN_RST 1'h0
`define BMPM_CS_LEGACY    1'h1
`endif

// File: common/bmpm_pkg.sv
// Types of the boot mode and program map block.
// Assumes the defines header is on the include path.
`include "bmpm_defines.svh"
package bmpm_pkg;
    typedef enum logic {PH_HOLD, PH_RUN} bmpm_phase_t;
    typedef enum logic [2:0] {
        TGT_FLASH0, TGT_FLASH1, TGT_BOOT, TGT_RAM, TGT_EXT, TGT_RSVD, TGT_BLOCKED
    } bmpm_target_t;
    typedef struct packed {
        bmpm_phase_t                 phase;
        logic [`BMPM_CNT_W-1:0]      hold_cnt;
        logic                        core_reset_n;
        logic                        boot_s1;
        logic                        boot_s2;
        logic                        wide_s1;
        logic                        wide_s2;
        logic                        snapshot;
        logic                        layout;
        logic                        boot_ext;
        logic                        wide;
        logic                        osc_gain;
        logic                        cs0_prog;
        logic                        cs1_data;
        logic                        debug_en;
        logic [3:0]                  hi_en;
        logic [4:0]                  addr_lines;
        logic                        shadow_ok;
        logic [`BMPM_PADDR_W-1:0]    reset_vec;
        logic [`BMPM_PADDR_W-1:0]    cop_vec;
        logic                        rsp_valid;
        bmpm_target_t                rsp_target;
        logic                        rsp_conflict;
        logic                        flash_wr_accept;
        logic                        grant_core;
        logic                        grant_sec;
    } bmpm_state_t;
endpackage : bmpm_pkg

// File: common/bmpm_map_if.sv
// Carrier between the mode logic and the program address decoder.
// Assumes both ends sit on the same clock; the decoder is purely combinational.
`timescale 1ns/1ps
`include "bmpm_defines.svh"
interface bmpm_map_if;
    logic                       layout;
    logic                       snapshot;
    logic                       wide;
    logic                       hi_cfg;
    logic [`BMPM_PADDR_W-1:0]   addr;
    logic [1:0]                 busy;
    bmpm_pkg::bmpm_target_t     target;
    logic                       conflict;
    modport ctl (output layout, snapshot, wide, hi_cfg, addr, busy, input target, conflict);
    modport dec (input layout, snapshot, wide, hi_cfg, addr, busy, output target, conflict);
endinterface : bmpm_map_if

// File: hw/bmpm_map_decode.sv
// Program address decoder for the current operating mode.
// Assumes mode bits are stable registers and the caller registers the result.
`timescale 1ns/1ps
`include "bmpm_defines.svh"
module bmpm_map_decode (
    // Mode and address in, target out
    bmpm_map_if.dec m
);
    logic [`BMPM_PADDR_W-1:0] reach;

    // =====================================================================
    // Region decode
    always_comb begin
        reach = m.wide ? `BMPM_WIDE_END : `BMPM_EXT_LOW_END;
        if (m.addr <= `BMPM_EXT_LOW_END) begin
            m.target = m.layout ? bmpm_pkg::TGT_EXT : bmpm_pkg::TGT_FLASH0;
        end else if (m.addr <= `BMPM_FLASH_END) begin
            m.target = (m.addr >= `BMPM_FLASH1_BASE) ? bmpm_pkg::TGT_FLASH1 : bmpm_pkg::TGT_FLASH0;
        end else if (m.addr <= `BMPM_BOOT_END) begin
            // Narrow external boot keeps the boot flash visible for data use.
            m.target = (m.layout && m.wide) ? bmpm_pkg::TGT_EXT : bmpm_pkg::TGT_BOOT;
        end else if (m.addr < `BMPM_RAM_BASE) begin
            m.target = bmpm_pkg::TGT_RSVD;
        end else if (m.addr <= `BMPM_RAM_END) begin
            m.target = bmpm_pkg::TGT_RAM;
        end else if (m.addr > reach && !m.hi_cfg) begin
            m.target = bmpm_pkg::TGT_BLOCKED;
        end else begin
            m.target = bmpm_pkg::TGT_EXT;
        end
        if (m.target == bmpm_pkg::TGT_EXT && !m.snapshot) begin
            m.target = bmpm_pkg::TGT_BLOCKED;
        end
        // A fetch from a block under program or erase must wait for it.
        m.conflict = (m.target == bmpm_pkg::TGT_FLASH0 && m.busy[0])
                  || (m.target == bmpm_pkg::TGT_FLASH1 && m.busy[1]);
    end
endmodule : bmpm_map_decode

// File: hw/bmpm_top.sv
// Boot mode capture, internal reset release and program space map.
// Assumes strap pins are asynchronous and flash status, software writes and
// bus requests come from logic on clk_sys.
`timescale 1ns/1ps
`include "bmpm_defines.svh"
module bmpm_top #(
    parameter int RESET_HOLD = `BMPM_RESET_HOLD
) (
    // Clock and reset
    input  wire logic                       clk_sys,
    input  wire logic                       resetn,
    // Strap pins and flash state
    input  wire logic                       external_boot_pin,
    input  wire logic                       wide_address_select,
    input  wire logic                       flash_unsecured,
    input  wire logic                       hi_addr_pins_ready,
    input  wire logic [1:0]                 flash_block_busy,
    // Software writes
    input  wire logic                       omr_wr_en,
    input  wire logic                       omr_wr_layout,
    input  wire logic                       osc_wr_en,
    input  wire logic                       osc_wr_high_gain,
    // Program fetch
    input  wire logic                       prog_req_valid,
    input  wire logic [`BMPM_PADDR_W-1:0]   prog_addr,
    // Flash programming path
    input  wire logic                       fiu_cmd_valid,
    input  wire logic                       fiu_from_core_write_bus,
    input  wire logic                       fiu_single_word,
    // Data flash readers
    input  wire logic                       core_read_bus_req,
    input  wire logic                       secondary_data_bus_req,
    // Reset and mode state
    output logic                            core_reset_n,
    output logic                            program_layout_bit,
    output logic                            secured_snapshot_bit,
    output logic                            external_boot_active,
    output logic                            oscillator_high_gain_select,
    output logic                            chip_select_zero_is_program_strobe,
    output logic                            chip_select_one_is_data_strobe,
    output logic                            enhanced_debug_port_enable,
    // External address configuration
    output logic [4:0]                      ext_addr_line_count,
    output logic [3:0]                      ext_addr_hi_enable,
    output logic                            shadow_capable,
    output logic [`BMPM_PADDR_W-1:0]        reset_vector_addr,
    output logic [`BMPM_PADDR_W-1:0]        cop_vector_addr,
    // Fetch answer
    output logic                            prog_rsp_valid,
    output bmpm_pkg::bmpm_target_t          prog_rsp_target,
    output logic                            prog_rsp_conflict,
    // Flash write and read arbitration
    output logic                            flash_wr_accept,
    output logic                            grant_core_read_bus,
    output logic                            grant_secondary_data_bus
);
    localparam logic [`BMPM_CNT_W-1:0] HOLD_LAST = `BMPM_CNT_W'(RESET_HOLD - 1);
    localparam bmpm_pkg::bmpm_state_t ST_RESET = '{
        phase:      bmpm_pkg::PH_HOLD,
        rsp_target: bmpm_pkg::TGT_FLASH0,
        osc_gain:   `BMPM_OSC_GAIN_RST,
        cs0_prog:   `BMPM_CS_LEGACY,
        cs1_data:   `BMPM_CS_LEGACY,
        addr_lines: `BMPM_LINES_NARROW,
        reset_vec:  `BMPM_BOOT_BASE,
        cop_vec:    `BMPM_BOOT_BASE + `BMPM_COP_OFFSET,
        default:    '0
    };

    bmpm_pkg::bmpm_state_t state_reg;
    bmpm_pkg::bmpm_state_t state_next;

    logic                       cap_ext;
    logic                       cap_wide;
    logic [4:0]                 cap_lines;
    logic [`BMPM_PADDR_W-1:0]   cap_vec;
    logic                       in_run;

    bmpm_map_if map_if ();

    // =====================================================================
    // Reset-time mode capture
    // Secured flash vetoes the boot pin, so the 01 combination never forms.
    assign cap_ext   = flash_unsecured & state_reg.boot_s2;
    assign cap_wide  = cap_ext & state_reg.wide_s2;
    assign cap_lines = cap_wide ? `BMPM_LINES_WIDE : `BMPM_LINES_NARROW;
    assign cap_vec   = (cap_ext && !cap_wide) ? `BMPM_EXT_BOOT_VEC : `BMPM_BOOT_BASE;
    assign in_run    = (state_reg.phase == bmpm_pkg::PH_RUN);

    // =====================================================================
    // Program address decoder
    assign map_if.layout   = state_reg.layout;
    assign map_if.snapshot = state_reg.snapshot;
    assign map_if.wide     = state_reg.wide;
    assign map_if.hi_cfg   = hi_addr_pins_ready;
    assign map_if.addr     = prog_addr;
    assign map_if.busy     = flash_block_busy;

    bmpm_map_decode u_decode (
        .m (map_if.dec)
    );

    // =====================================================================
    // Next state
    always_comb begin
        state_next = state_reg;
        // Strap pins are asynchronous; only the second stage is ever read.
        state_next.boot_s1 = external_boot_pin;
        state_next.boot_s2 = state_reg.boot_s1;
        state_next.wide_s1 = wide_address_select;
        state_next.wide_s2 = state_reg.wide_s1;
        state_next.rsp_valid       = 1'b0;
        state_next.flash_wr_accept = 1'b0;
        state_next.grant_core      = 1'b0;
        state_next.grant_sec       = 1'b0;
        case (state_reg.phase)
            bmpm_pkg::PH_HOLD: begin
                if (state_reg.hold_cnt == HOLD_LAST) begin
                    // Everything is taken in the one release cycle so the map
                    // never shows a mix of old and new straps.
                    state_next.phase        = bmpm_pkg::PH_RUN;
                    state_next.core_reset_n = 1'b1;
                    state_next.snapshot     = flash_unsecured;
                    state_next.layout       = cap_ext;
                    state_next.boot_ext     = cap_ext;
                    state_next.wide         = cap_wide;
                    state_next.debug_en     = flash_unsecured;
                    state_next.addr_lines   = cap_lines;
                    state_next.hi_en        = cap_wide ? `BMPM_HI_ADDR_ON : `BMPM_HI_ADDR_OFF;
                    state_next.shadow_ok    = (cap_lines >= `BMPM_LINES_SHADOW);
                    state_next.reset_vec    = cap_vec;
                    state_next.cop_vec      = cap_vec + `BMPM_COP_OFFSET;
                    state_next.cs0_prog     = `BMPM_CS_LEGACY;
                    state_next.cs1_data     = `BMPM_CS_LEGACY;
                end else begin
                    state_next.hold_cnt = state_reg.hold_cnt + 1'b1;
                end
            end
            bmpm_pkg::PH_RUN: begin
                if (osc_wr_en) begin
                    state_next.osc_gain = osc_wr_high_gain;
                end
                // The secured bit has no write path at all, so software can
                // never reach the map or the flash security through it.
                if (omr_wr_en && state_reg.snapshot) begin
                    state_next.layout = omr_wr_layout;
                end
                if (prog_req_valid) begin
                    state_next.rsp_valid    = 1'b1;
                    state_next.rsp_target   = map_if.target;
                    state_next.rsp_conflict = map_if.conflict;
                end
                state_next.flash_wr_accept = fiu_cmd_valid && fiu_from_core_write_bus
                                           && fiu_single_word;
                // The core read bus wins a tie; the loser simply asks again.
                state_next.grant_core = core_read_bus_req;
                state_next.grant_sec  = secondary_data_bus_req && !core_read_bus_req;
            end
            default: begin
                state_next.phase = bmpm_pkg::PH_HOLD;
            end
        endcase
    end

    // =====================================================================
    // State register
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_reg <= ST_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // =====================================================================
    // Outputs
    assign core_reset_n                       = state_reg.core_reset_n;
    assign program_layout_bit                 = state_reg.layout;
    assign secured_snapshot_bit               = state_reg.snapshot;
    assign external_boot_active               = state_reg.boot_ext;
    assign oscillator_high_gain_select        = state_reg.osc_gain;
    assign chip_select_zero_is_program_strobe = state_reg.cs0_prog;
    assign chip_select_one_is_data_strobe     = state_reg.cs1_data;
    assign enhanced_debug_port_enable         = state_reg.debug_en;
    assign ext_addr_line_count                = state_reg.addr_lines;
    assign ext_addr_hi_enable                 = state_reg.hi_en;
    assign shadow_capable                     = state_reg.shadow_ok;
    assign reset_vector_addr                  = state_reg.reset_vec;
    assign cop_vector_addr                    = state_reg.cop_vec;
    assign prog_rsp_valid                     = state_reg.rsp_valid;
    assign prog_rsp_target                    = state_reg.rsp_target;
    assign prog_rsp_conflict                  = state_reg.rsp_conflict;
    assign flash_wr_accept                    = state_reg.flash_wr_accept;
    assign grant_core_read_bus                = state_reg.grant_core;
    assign grant_secondary_data_bus           = state_reg.grant_sec;

    // =====================================================================
    // Checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);

    sequence s_hold_done;
        state_reg.phase == bmpm_pkg::PH_HOLD && state_reg.hold_cnt == HOLD_LAST;
    endsequence

    sequence s_released;
        in_run && core_reset_n;
    endsequence

    chk_reset_release: assert property (
        s_hold_done |=> s_released
    ) else $error("internal reset not released after the hold count");

    chk_reset_hold_low: assert property (
        !in_run |-> !core_reset_n && !prog_rsp_valid && !grant_core_read_bus
    ) else $error("core reset released or traffic served during hold");

    chk_osc_gain_reset: assert property (
        !in_run |-> !oscillator_high_gain_select
    ) else $error("oscillator gain not at its reset value during hold");

    chk_osc_gain_write: assert property (
        in_run && osc_wr_en |=> oscillator_high_gain_select == $past(osc_wr_high_gain)
    ) else $error("oscillator gain write not taken");

    chk_mode_capture: assert property (
        s_hold_done |=> secured_snapshot_bit == $past(flash_unsecured)
                     && program_layout_bit == $past(flash_unsecured && state_reg.boot_s2)
    ) else $error("mode bits not captured at reset release");

    chk_secure_override: assert property (
        $rose(core_reset_n) && !secured_snapshot_bit |-> !program_layout_bit && !external_boot_active
    ) else $error("secured flash did not force internal boot");

    chk_secured_lines: assert property (
        in_run && !secured_snapshot_bit |-> ext_addr_line_count == `BMPM_LINES_NARROW
                                         && !enhanced_debug_port_enable && ext_addr_hi_enable == `BMPM_HI_ADDR_OFF
    ) else $error("secured mode drives wrong lines or enables debug");

    chk_secured_no_ext: assert property (
        prog_rsp_valid && !secured_snapshot_bit |-> prog_rsp_target != bmpm_pkg::TGT_EXT
    ) else $error("external program access while secured");

    chk_wide_lines: assert property (
        s_hold_done ##1 external_boot_active |-> ext_addr_line_count == ($past(state_reg.wide_s2, 1)
                                                 ? `BMPM_LINES_WIDE : `BMPM_LINES_NARROW)
    ) else $error("address line count does not follow the wide strap");

    chk_ext_boot_entry: assert property (
        s_hold_done and (flash_unsecured && state_reg.boot_s2) |=> external_boot_active
    ) else $error("external boot not entered when allowed");

    chk_snapshot_stable: assert property (
        in_run && $past(in_run) |-> $stable(secured_snapshot_bit)
    ) else $error("secured bit changed after reset");

    chk_layout_locked: assert property (
        in_run && !secured_snapshot_bit |-> !program_layout_bit
    ) else $error("layout bit changed while secured at reset");

    chk_layout_write: assert property (
        in_run && secured_snapshot_bit && omr_wr_en |=> program_layout_bit == $past(omr_wr_layout)
    ) else $error("layout write not taken");

    chk_strobe_config: assert property (
        $rose(core_reset_n) |-> chip_select_zero_is_program_strobe && chip_select_one_is_data_strobe
    ) else $error("chip selects not in legacy strobe mode");

    chk_narrow_vector: assert property (
        in_run && external_boot_active && ext_addr_line_count == `BMPM_LINES_NARROW
        |-> reset_vector_addr == `BMPM_EXT_BOOT_VEC
         && cop_vector_addr == `BMPM_EXT_BOOT_VEC + `BMPM_COP_OFFSET
    ) else $error("narrow external boot vectors wrong");

    chk_boot_vector: assert property (
        in_run && !external_boot_active |-> reset_vector_addr == `BMPM_BOOT_BASE
                                         && cop_vector_addr == `BMPM_BOOT_BASE + `BMPM_COP_OFFSET
    ) else $error("internal boot vectors wrong");

    chk_fetch_answer: assert property (
        in_run && prog_req_valid && prog_addr > `BMPM_WIDE_END && !hi_addr_pins_ready
        |=> prog_rsp_valid && prog_rsp_target == bmpm_pkg::TGT_BLOCKED
    ) else $error("unreachable external address was not blocked");

    chk_busy_block: assert property (
        prog_rsp_valid && prog_rsp_target == bmpm_pkg::TGT_FLASH1 |-> prog_rsp_conflict == $past(flash_block_busy[1])
    ) else $error("busy flash block not flagged");

    chk_shadow_lines: assert property (
        in_run |-> shadow_capable == (ext_addr_line_count >= `BMPM_LINES_SHADOW)
    ) else $error("shadow flag disagrees with line count");

    chk_flash_write: assert property (
        flash_wr_accept |-> $past(fiu_cmd_valid && fiu_from_core_write_bus && fiu_single_word)
    ) else $error("flash write accepted from a wrong source");

    chk_read_grant: assert property (
        !(grant_core_read_bus && grant_secondary_data_bus)
    ) else $error("data flash granted to both buses");
endmodule : bmpm_top

// File: verification/bmpm_strap_model.sv
// Strap pins and flash security source facing the mode logic.
// Assumes the bench sets cfg well before reset release.
`timescale 1ns/1ps
module bmpm_strap_model (
    // Selected strap setup
    input  wire logic [2:0] cfg,
    // Pins and flash state
    output logic            flash_unsecured,
    output logic            external_boot_pin,
    output logic            wide_address_select
);
    assign {flash_unsecured, external_boot_pin, wide_address_select} = cfg;
endmodule : bmpm_strap_model

// File: verification/tb_top.sv
// Self-checking bench for the boot mode and program map block.
// Assumes RESET_HOLD of 4 and the program map of the defines header.
`timescale 1ns/1ps
`include "bmpm_defines.svh"
`define CHK(n,e,a) begin checks++; if ((a)!==(e)) begin bad_count++; $display("ERROR %s exp %0h got %0h",n,e,a); end end
module tb_top;
    logic clk_sys=0, resetn=0, hi=0, owe=0, owl=0, swe=0, swg=0, pv=0, fv=0, fc=0, fs=0, cr=0, sr=0;
    logic fu, eb, wa, crn, lay, snap, ext, osc, cs0, cs1, dbg, shd, pr, pc, fa, gc, gs, el, es, ew;
    logic [1:0] busy=0; logic [2:0] cfg=0; logic [4:0] lines; logic [3:0] hen, e; logic [20:0] pa=0, rv, cv;
    bmpm_pkg::bmpm_target_t pt; int bad_count=0, checks=0, cyc=0; logic [3:0] q[$];
    always #12.5 clk_sys = ~clk_sys;
    bmpm_strap_model u_bmpm_strap_model (.cfg(cfg), .flash_unsecured(fu), .external_boot_pin(eb),
        .wide_address_select(wa));
    bmpm_top #(.RESET_HOLD(4)) u_bmpm_top (.clk_sys(clk_sys), .resetn(resetn), .external_boot_pin(eb),
        .wide_address_select(wa), .flash_unsecured(fu), .hi_addr_pins_ready(hi), .flash_block_busy(busy),
        .omr_wr_en(owe), .omr_wr_layout(owl), .osc_wr_en(swe), .osc_wr_high_gain(swg), .prog_req_valid(pv),
        .prog_addr(pa), .fiu_cmd_valid(fv), .fiu_from_core_write_bus(fc), .fiu_single_word(fs),
        .core_read_bus_req(cr), .secondary_data_bus_req(sr), .core_reset_n(crn), .program_layout_bit(lay),
        .secured_snapshot_bit(snap), .external_boot_active(ext), .oscillator_high_gain_select(osc),
        .chip_select_zero_is_program_strobe(cs0), .chip_select_one_is_data_strobe(cs1),
        .enhanced_debug_port_enable(dbg), .ext_addr_line_count(lines), .ext_addr_hi_enable(hen),
        .shadow_capable(shd), .reset_vector_addr(rv), .cop_vector_addr(cv), .prog_rsp_valid(pr),
        .prog_rsp_target(pt), .prog_rsp_conflict(pc), .flash_wr_accept(fa), .grant_core_read_bus(gc),
        .grant_secondary_data_bus(gs));
    // ======================================================================
    // Expected fetch answer, packed as conflict over target code.
    function automatic logic [3:0] expf(input logic [20:0] a);
        logic [2:0] t;
        t = a[20] ? (hi ? 3'h4 : 3'h6) : !a[18] ? (a[17] ? 3'h1 : (a[16] || !el) ? 3'h0 : 3'h4)
          : (a[15:11] == 5'h1f) ? 3'h3 : (a[15:14] != 2'h0) ? 3'h5 : (el && ew ? 3'h4 : 3'h2);
        if (t == 3'h4 && !es) t = 3'h6;
        return {(t == 3'h0 && busy[0]) || (t == 3'h1 && busy[1]), t};
    endfunction : expf
    task automatic fetch(input logic [20:0] a);
        {hi, busy} = 3'($urandom);
        pa = a;
        pv = 1;
        q.push_back(expf(a));
        @(posedge clk_sys) #2;
    endtask : fetch
    task automatic test_done;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : test_done
    // ======================================================================
    // Fetch answers are taken off the note queue in arrival order.
    always @(negedge clk_sys) if (pr === 1'b1) begin
        e = q.size() ? q.pop_front() : 4'hf;
        `CHK("fetch", e, {pc, pt})
    end
    always @(posedge clk_sys) if (++cyc > 5000) begin
        bad_count++;
        test_done;
    end
    initial begin
        void'($urandom(51));
        for (int c = 0; c < 8; c++) begin
            resetn = 0;
            cfg = 3'(c);
            repeat (20) @(posedge clk_sys);
            #2 resetn = 1;
            for (int i = 0; i < 40 && crn !== 1'b1; i++) @(posedge clk_sys) #2;
            es = cfg[2]; el = cfg[2] & cfg[1]; ew = el & cfg[0];
            `CHK("mode", {es, el, el, es, 3'h7}, {snap, lay, ext, dbg, cs0, cs1, !osc})
            `CHK("lines", {ew ? 5'h14 : 5'h10, ew ? 4'hf : 4'h0, ew}, {lines, hen, shd})
            `CHK("vec", {el && !ew ? 21'h0 : 21'h040000}, rv)
            `CHK("cop", {el && !ew ? 21'h000002 : 21'h040002}, cv)
            cfg[2] = ~cfg[2];
            owe = 1; owl = 1; swe = 1; swg = 1;
            @(posedge clk_sys) #2;
            owe = 0; swe = 0; el = es;
            fetch(21'h000002); fetch(21'h020000); fetch(21'h040000);
            fetch(21'h04c000); fetch(21'h04f800); fetch(21'h100000);
            pv = 0;
            `CHK("wr", {es, es, 1'b1}, {snap, lay, osc})
            for (int i = 0; i < 4; i++) begin
                {fc, fs, cr, sr} = 4'($urandom);
                fv = 1;
                @(posedge clk_sys) #2;
                `CHK("arb", {fc & fs, cr, sr & !cr}, {fa, gc, gs})
            end
            {fv, cr, sr} = 3'h0;
        end
        `CHK("queue", 0, q.size())
        test_done;
    end
endmodule : tb_top
